// ===== ircc_pkg.sv
// Package for the internal reset cause control block.
// Assumes a single 50 MHz clock and a plain register port with 8-bit data.
package ircc_pkg;

  // ==========================================================
  // Register map (word index; byte address is index * 4)
  // ==========================================================
  localparam logic [3:0] IRCC_ADDR_CAUSE = 4'h0;
  localparam logic [3:0] IRCC_ADDR_SYSCFG3 = 4'h1;
  localparam logic [3:0] IRCC_ADDR_KEY = 4'h2;
  localparam logic [3:0] IRCC_ADDR_IRQ_STAT = 4'h3;
  localparam logic [3:0] IRCC_ADDR_IRQ_MASK = 4'h4;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int IRCC_BIT_VDET = 0;
  localparam int IRCC_BIT_WDT = 1;
  localparam int IRCC_BIT_CLK = 2;
  localparam int IRCC_BIT_TRIM = 3;
  localparam int IRCC_BIT_TRIM_FAULT = 6;
  localparam int IRCC_BIT_CLEAR_REQ = 7;
  localparam int IRCC_BIT_PIN_RST_DIS = 0;
  localparam int IRCC_NUM_CAUSES = 4;

  // ==========================================================
  // Keys and reset values
  // ==========================================================
  localparam logic [7:0] IRCC_KEY_CLEAR = 8'h71;
  localparam logic [7:0] IRCC_KEY_PIN = 8'hB2;
  localparam logic [7:0] IRCC_ZERO8 = 8'h00;
  localparam logic [3:0] IRCC_ZERO4 = 4'h0;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int IRCC_CLK_MHZ = 50;
  localparam int IRCC_RST_PULSE_NS = 200;
  localparam int IRCC_RST_PULSE_CYC = (IRCC_RST_PULSE_NS * IRCC_CLK_MHZ + 999) / 1000;
  localparam int IRCC_WARMUP_US = 20;
  localparam int IRCC_WARMUP_CYC = IRCC_WARMUP_US * IRCC_CLK_MHZ;

  typedef enum logic [1:0] {
    IRCC_ST_RESET,
    IRCC_ST_WARMUP,
    IRCC_ST_RUN
  } ircc_state_e;

endpackage : ircc_pkg

// ===== ircc_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level is stable long enough to be seen by the clock.
`timescale 1ns/1ps
module ircc_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Level
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;

  // ==========================================================
  // Synchroniser, resets to high as an idle pin level
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // ircc_sync

// ===== ircc_top.sv
// Internal reset cause control: internal reset request, cause record,
// warm-up with trim fetch, keyed clear and reset-pin role switch.
// Assumes rst_n is the power-on reset and event inputs share the clock.
//
// Overview of operation
// - Voltage detection event raises an internal reset.
// - Watchdog overflow raises an internal reset.
// - Deadlocking oscillator-enable setting raises an internal reset.
// - Corrupted latched trim bits during operation raise an internal reset.
// - Warm-up after any reset fetches trim bits into an internal latch.
// - Abnormal trim bits fetched during warm-up set the trim fault flag.
// - Cause status shows which internal source produced the last reset.
// - Cause status cleared by pin or power-on reset, not by internal resets.
// - Clear request bit then key 0x71 clears the four cause bits, not the trim fault flag.
// - Clear request bit returns to zero after the clear.
// - Disable bit then key 0xB2 turns the reset pin into a port.
// - Cleared disable bit then key 0xB2 restores the pin reset role.
// - Power-on reset and pin reset are ORed together.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ircc_top
  import ircc_pkg::*;
#(
  parameter int WARMUP_CYC = IRCC_WARMUP_CYC
) (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic rst_n,
  // Reset pin level, low active when in reset role
  input wire logic reset_pin_n,
  // Internal reset sources
  input wire logic vdet_event,
  input wire logic wdt_overflow,
  input wire logic osc_enable_write,
  input wire logic [1:0] osc_enable_value,
  // Trim storage fetch and latch check
  input wire logic [7:0] trim_store_data,
  input wire logic trim_store_valid,
  input wire logic trim_store_error,
  input wire logic trim_latch_corrupt,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // System outputs
  output logic sys_reset_n,
  output logic warmup_busy,
  output logic [7:0] trim_latch,
  output logic pin_port_mode,
  output logic pin_port_level,
  output logic irq
);

  // ==========================================================
  // Declarations
  // ==========================================================
  ircc_state_e state_ff;
  ircc_state_e nxt_state;
  logic pin_sync;
  logic pin_rst_n;
  logic chip_rst_n;
  logic [IRCC_NUM_CAUSES-1:0] cause_ff;
  logic [IRCC_NUM_CAUSES-1:0] cause_hit;
  logic trim_fault_ff;
  logic clear_req_ff;
  logic pin_dis_pend_ff;
  logic pin_dis_ff;
  logic [7:0] trim_ff;
  logic [15:0] cnt_ff;
  logic [IRCC_NUM_CAUSES-1:0] irq_stat_ff;
  logic [IRCC_NUM_CAUSES-1:0] irq_mask_ff;
  logic [7:0] rdata_ff;
  logic int_req;
  logic wr_key;
  logic key_clear;
  logic key_pin;
  logic [15:0] warm_last;

  function automatic logic is_wr(input logic [3:0] a, input logic [3:0] sel,
                                 input logic we);
    is_wr = we && (a == sel);
  endfunction

  // ==========================================================
  // Reset combination
  // ==========================================================
  ircc_sync u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(reset_pin_n),
    .sync_out(pin_sync)
  );

  // Pin acts as reset only while the port role is not applied
  assign pin_rst_n = pin_dis_ff ? 1'b1 : pin_sync;
  assign chip_rst_n = rst_n & pin_rst_n;

  // A deadlock combination is both oscillators disabled
  assign cause_hit[IRCC_BIT_VDET] = vdet_event;
  assign cause_hit[IRCC_BIT_WDT] = wdt_overflow;
  assign cause_hit[IRCC_BIT_CLK] = osc_enable_write && (osc_enable_value == 2'b00);
  assign cause_hit[IRCC_BIT_TRIM] = trim_latch_corrupt && (state_ff == IRCC_ST_RUN);
  assign int_req = (state_ff == IRCC_ST_RUN) && (|cause_hit);

  assign wr_key = is_wr(reg_addr, IRCC_ADDR_KEY, reg_write);
  assign key_clear = wr_key && (reg_wdata == IRCC_KEY_CLEAR);
  assign key_pin = wr_key && (reg_wdata == IRCC_KEY_PIN);
  assign warm_last = 16'(WARMUP_CYC - 1);

  // ==========================================================
  // Sequencer: reset pulse, warm-up, run
  // ==========================================================
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IRCC_ST_RESET: begin
        if (cnt_ff == 16'(IRCC_RST_PULSE_CYC - 1)) begin
          nxt_state = IRCC_ST_WARMUP;
        end
      end
      IRCC_ST_WARMUP: begin
        if (cnt_ff == warm_last) begin
          nxt_state = IRCC_ST_RUN;
        end
      end
      IRCC_ST_RUN: begin
        if (int_req) begin
          nxt_state = IRCC_ST_RESET;
        end
      end
      default: nxt_state = IRCC_ST_RESET;
    endcase
  end

  // Pin or power-on reset restarts the sequence too
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= IRCC_ST_RESET;
      cnt_ff <= 16'h0000;
    end else if (!chip_rst_n) begin
      state_ff <= IRCC_ST_RESET;
      cnt_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (nxt_state != state_ff) ? 16'h0000 : cnt_ff + 16'h0001;
    end
  end

  assign sys_reset_n = (state_ff == IRCC_ST_RUN);
  assign warmup_busy = (state_ff == IRCC_ST_WARMUP);

  // ==========================================================
  // Trim fetch during warm-up
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trim_ff <= IRCC_ZERO8;
      trim_fault_ff <= 1'b0;
    end else if (state_ff == IRCC_ST_RESET) begin
      trim_fault_ff <= 1'b0;
    end else if (warmup_busy && trim_store_valid) begin
      trim_ff <= trim_store_data;
      trim_fault_ff <= trim_store_error;
    end
  end

  assign trim_latch = trim_ff;

  // ==========================================================
  // Cause status: kept across internal resets
  // ==========================================================
  // Asynchronous clear from rst_n only; pin reset clears synchronously
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cause_ff <= IRCC_ZERO4;
    end else if (!pin_rst_n) begin
      cause_ff <= IRCC_ZERO4;
    end else if (int_req) begin
      cause_ff <= cause_hit;
    end else if (clear_req_ff && key_clear) begin
      cause_ff <= IRCC_ZERO4;
    end
  end

  // Clear request bit, self-clears once the clear has been done
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clear_req_ff <= 1'b0;
    end else if (clear_req_ff && key_clear) begin
      clear_req_ff <= 1'b0;
    end else if (is_wr(reg_addr, IRCC_ADDR_CAUSE, reg_write)) begin
      clear_req_ff <= reg_wdata[IRCC_BIT_CLEAR_REQ];
    end
  end

  // ==========================================================
  // Pin role: pending bit applied by key
  // ==========================================================
  // Applied setting changes only by key or power-on reset, not by pin or internal resets
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_dis_pend_ff <= 1'b0;
      pin_dis_ff <= 1'b0;
    end else begin
      if (is_wr(reg_addr, IRCC_ADDR_SYSCFG3, reg_write)) begin
        pin_dis_pend_ff <= reg_wdata[IRCC_BIT_PIN_RST_DIS];
      end
      if (key_pin) begin
        pin_dis_ff <= pin_dis_pend_ff;
      end
    end
  end

  assign pin_port_mode = pin_dis_ff;
  assign pin_port_level = pin_dis_ff & pin_sync;

  // ==========================================================
  // Interrupt status and mask
  // ==========================================================
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= IRCC_ZERO4;
    end else if (is_wr(reg_addr, IRCC_ADDR_IRQ_STAT, reg_write)) begin
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata[IRCC_NUM_CAUSES-1:0])
                     | (int_req ? cause_hit : IRCC_ZERO4);
    end else if (int_req) begin
      irq_stat_ff <= irq_stat_ff | cause_hit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_ff <= IRCC_ZERO4;
    end else if (is_wr(reg_addr, IRCC_ADDR_IRQ_MASK, reg_write)) begin
      irq_mask_ff <= reg_wdata[IRCC_NUM_CAUSES-1:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ==========================================================
  // Read data, one cycle after the strobe
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= IRCC_ZERO8;
    end else if (reg_read) begin
      case (reg_addr)
        IRCC_ADDR_CAUSE:
          rdata_ff <= {clear_req_ff, trim_fault_ff, 2'b00, cause_ff};
        IRCC_ADDR_SYSCFG3: rdata_ff <= {7'h00, pin_dis_pend_ff};
        IRCC_ADDR_IRQ_STAT: rdata_ff <= {4'h0, irq_stat_ff};
        IRCC_ADDR_IRQ_MASK: rdata_ff <= {4'h0, irq_mask_ff};
        default: rdata_ff <= IRCC_ZERO8;
      endcase
    end else begin
      rdata_ff <= IRCC_ZERO8;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================================
  // Checks
  // ==========================================================
  vdet_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sys_reset_n && vdet_event && pin_rst_n) |=> !sys_reset_n)
    else $error("voltage event did not reset");

  wdt_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sys_reset_n && wdt_overflow && pin_rst_n) |=> (!sys_reset_n && cause_ff[IRCC_BIT_WDT]))
    else $error("watchdog overflow not recorded");

  clk_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sys_reset_n && osc_enable_write && osc_enable_value == 2'b00 && pin_rst_n)
    |=> cause_ff[IRCC_BIT_CLK])
    else $error("clock deadlock not recorded");

  trim_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sys_reset_n && trim_latch_corrupt && pin_rst_n) |=> !sys_reset_n)
    else $error("trim corruption did not reset");

  trim_fetch_a: assert property (@(posedge clock) disable iff (!rst_n)
    (warmup_busy && trim_store_valid && pin_rst_n) |=> (trim_latch == $past(trim_store_data)))
    else $error("trim not latched");

  trim_fault_a: assert property (@(posedge clock) disable iff (!rst_n)
    (warmup_busy && trim_store_valid && trim_store_error && pin_rst_n) |=> trim_fault_ff)
    else $error("trim fault not flagged");

  cause_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_ff != IRCC_ST_RUN && pin_rst_n) |=> $stable(cause_ff))
    else $error("cause lost across internal reset");

  cause_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (clear_req_ff && key_clear && !int_req && pin_rst_n) |=> (cause_ff == IRCC_ZERO4))
    else $error("cause not cleared by key");

  req_selfclr_a: assert property (@(posedge clock) disable iff (!rst_n)
    (clear_req_ff && key_clear) |=> !clear_req_ff)
    else $error("clear request stuck");

  pin_apply_a: assert property (@(posedge clock) disable iff (!rst_n)
    key_pin |=> (pin_port_mode == $past(pin_dis_pend_ff)))
    else $error("pin role not applied");

  wrong_key_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_key && !key_pin) |=> $stable(pin_port_mode))
    else $error("pin role changed without key");

  pin_or_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!pin_rst_n) |=> !sys_reset_n)
    else $error("pin reset not honoured");

  vdet_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sys_reset_n && vdet_event && pin_rst_n) |=> cause_ff[IRCC_BIT_VDET])
    else $error("voltage cause not recorded");

  trim_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sys_reset_n && trim_latch_corrupt && pin_rst_n) |=> cause_ff[IRCC_BIT_TRIM])
    else $error("trim cause not recorded");

  pin_restore_a: assert property (@(posedge clock) disable iff (!rst_n)
    (key_pin && !pin_dis_pend_ff) |=> !pin_port_mode)
    else $error("pin reset role not restored");

  // A low pin level must not reach the sequencer once the port role is applied
  port_no_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pin_dis_ff && sys_reset_n && !int_req) |=> sys_reset_n)
    else $error("port pin caused a reset");

endmodule // ircc_top

// ===== ircc_pin_model.sv
// Model of the board circuit that drives the reset pin.
// Assumes a pull-up on the pin and the block's 50 MHz clock.
`timescale 1ns/1ps
module ircc_pin_model (
  // Clock
  input wire logic clock,
  // Pin level
  output logic reset_pin_n
);
  // ==========================================================
  // Pin drive
  // ==========================================================
  // Pull-up holds the pin high from power-up through warm-up
  initial reset_pin_n = 1'b1;
  task automatic hold_low(input int cycles);
    @(posedge clock);
    reset_pin_n <= 1'b0;
    repeat (cycles) @(posedge clock);
    // Released pin returns to the pull-up level, never floats
    reset_pin_n <= 1'b1;
  endtask
endmodule // ircc_pin_model

// ===== ircc_tb.sv
// Self-checking testbench for the internal reset cause control block.
// Assumes ircc_pkg, ircc_top and ircc_pin_model are compiled first.
`timescale 1ns/1ps
module testbench;
  import ircc_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clock, rst_n, reset_pin_n, vdet_event, wdt_overflow, osc_enable_write;
  logic trim_store_valid, trim_store_error, trim_latch_corrupt, reg_write, reg_read;
  logic sys_reset_n, warmup_busy, pin_port_mode, pin_port_level, irq;
  logic [1:0] osc_enable_value;
  logic [3:0] reg_addr;
  logic [7:0] trim_store_data, reg_wdata, reg_rdata, trim_latch;
  int miscompares, samples_checked;
  localparam int WARM_CYC = 20;
  // Short warm-up keeps each reset sequence to a few dozen cycles
  ircc_top #(.WARMUP_CYC(WARM_CYC)) DUT (.clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .vdet_event(vdet_event), .wdt_overflow(wdt_overflow), .osc_enable_write(osc_enable_write),
    .osc_enable_value(osc_enable_value), .trim_store_data(trim_store_data),
    .trim_store_valid(trim_store_valid), .trim_store_error(trim_store_error),
    .trim_latch_corrupt(trim_latch_corrupt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sys_reset_n(sys_reset_n), .warmup_busy(warmup_busy), .trim_latch(trim_latch),
    .pin_port_mode(pin_port_mode), .pin_port_level(pin_port_level), .irq(irq));
  ircc_pin_model pin (.clock(clock), .reset_pin_n(reset_pin_n));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(name, reg_rdata, exp);
  endtask
  task automatic settle_chk(input string name, input logic seen_bit, input logic exp);
    chk(name, {7'h00, seen_bit}, {7'h00, exp});
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (!(sys_reset_n === 1'b1 && warmup_busy === 1'b0) && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic fire(input int src);
    @(posedge clock);
    case (src)
      0: vdet_event <= 1'b1;
      1: wdt_overflow <= 1'b1;
      2: osc_enable_write <= 1'b1;
      default: trim_latch_corrupt <= 1'b1;
    endcase
    osc_enable_value <= 2'b00;
    @(posedge clock);
    {vdet_event, wdt_overflow, osc_enable_write, trim_latch_corrupt} <= 4'h0;
    #1;
    settle_chk("sys_reset_n", sys_reset_n, 1'b0);
    settle_chk("warmup_busy", warmup_busy, 1'b0);
    repeat (IRCC_RST_PULSE_CYC) @(posedge clock);
    #1;
    settle_chk("warmup_busy", warmup_busy, 1'b1);
    repeat (WARM_CYC) @(posedge clock);
    #1;
    settle_chk("sys_reset_n", sys_reset_n, 1'b1);
    wait_run();
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic cause_scenario();
    logic [7:0] exp;
    @(posedge clock);
    osc_enable_write <= 1'b1;
    osc_enable_value <= 2'b01;
    @(posedge clock);
    osc_enable_write <= 1'b0;
    repeat (3) @(posedge clock);
    settle_chk("sys_reset_n", sys_reset_n, 1'b1);
    for (int i = 0; i < IRCC_NUM_CAUSES; i++) begin
      trim_store_data <= 8'(8'h30 + i);
      trim_store_error <= (i == IRCC_BIT_TRIM);
      fire(i);
      exp = (8'h01 << i) | ((i == IRCC_BIT_TRIM) ? 8'h40 : 8'h00);
      rd("cause", IRCC_ADDR_CAUSE, exp);
      chk("trim_latch", trim_latch, 8'(8'h30 + i));
    end
    // Fault seen after reset: force a clock-deadlock reset to refetch
    trim_store_error <= 1'b0;
    fire(2);
    rd("cause", IRCC_ADDR_CAUSE, 8'h04);
  endtask
  task automatic irq_scenario();
    wr(IRCC_ADDR_IRQ_STAT, 8'h0F);
    fire(1);
    rd("irq_stat", IRCC_ADDR_IRQ_STAT, 8'h02);
    settle_chk("irq", irq, 1'b0);
    wr(IRCC_ADDR_IRQ_MASK, 8'h02);
    #1;
    settle_chk("irq", irq, 1'b1);
    wr(IRCC_ADDR_IRQ_STAT, 8'h02);
    #1;
    settle_chk("irq", irq, 1'b0);
    rd("irq_stat", IRCC_ADDR_IRQ_STAT, 8'h00);
  endtask
  task automatic clear_scenario();
    wr(IRCC_ADDR_CAUSE, 8'h80);
    rd("cause", IRCC_ADDR_CAUSE, 8'h82);
    wr(IRCC_ADDR_KEY, 8'h70);
    rd("cause", IRCC_ADDR_CAUSE, 8'h82);
    wr(IRCC_ADDR_CAUSE, 8'h80);
    wr(IRCC_ADDR_KEY, IRCC_KEY_CLEAR);
    rd("cause", IRCC_ADDR_CAUSE, 8'h00);
  endtask
  task automatic pin_scenario();
    // Role switches happen only while the pin rests high
    wr(IRCC_ADDR_SYSCFG3, 8'h01);
    wr(IRCC_ADDR_KEY, IRCC_KEY_CLEAR);
    repeat (2) @(posedge clock);
    #1;
    settle_chk("pin_port_mode", pin_port_mode, 1'b0);
    wr(IRCC_ADDR_KEY, IRCC_KEY_PIN);
    repeat (2) @(posedge clock);
    #1;
    settle_chk("pin_port_mode", pin_port_mode, 1'b1);
    pin.hold_low(8);
    #1;
    settle_chk("sys_reset_n", sys_reset_n, 1'b1);
    settle_chk("pin_port_level", pin_port_level, 1'b0);
    repeat (4) @(posedge clock);
    #1;
    settle_chk("pin_port_level", pin_port_level, 1'b1);
    fire(1);
    settle_chk("pin_port_mode", pin_port_mode, 1'b1);
    rd("cause", IRCC_ADDR_CAUSE, 8'h02);
    wr(IRCC_ADDR_SYSCFG3, 8'h00);
    #1;
    // A stray clear of the disable bit alone must not restore the reset role
    settle_chk("pin_port_mode", pin_port_mode, 1'b1);
    wr(IRCC_ADDR_KEY, IRCC_KEY_PIN);
    repeat (2) @(posedge clock);
    #1;
    settle_chk("pin_port_mode", pin_port_mode, 1'b0);
    pin.hold_low(8);
    #1;
    settle_chk("sys_reset_n", sys_reset_n, 1'b0);
    wait_run();
    rd("cause", IRCC_ADDR_CAUSE, 8'h00);
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_n = 1'b0;
    {vdet_event, wdt_overflow, osc_enable_write, trim_latch_corrupt, trim_store_error} = 5'h00;
    {reg_write, reg_read} = 2'b00;
    trim_store_valid = 1'b1;
    osc_enable_value = 2'b11;
    trim_store_data = 8'h30;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    wait_run();
    rd("cause", IRCC_ADDR_CAUSE, 8'h00);
    rd("unmapped", 4'hF, 8'h00);
    settle_chk("irq", irq, 1'b0);
    cause_scenario();
    irq_scenario();
    clear_scenario();
    pin_scenario();
    conclude();
  end
endmodule // testbench
